// ==== hdl/true_dual_port_block_ram.sv ====
// true dual-port block memory: two ports, latch or pipe output stage,
// per-port write mode and width, APB setup and conflict status
// assumes both ports and APB run on clk; user logic drives both ports
`timescale 1ns/1ps
module true_dual_port_block_ram
  import tdp_ram_pkg::*;
#(
  parameter int          WR_LANES_A = 4,
  parameter int          RD_LANES_A = 4,
  parameter int          WR_LANES_B = 4,
  parameter int          RD_LANES_B = 4,
  parameter logic [35:0] PRESET_A   = 36'h0,
  parameter logic [35:0] PRESET_B   = 36'h0,
  parameter bit          CHAIN_EN   = 1'b0,
  parameter bit          CHAIN_BANK = 1'b0
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // port a
  input  wire logic              portSelectA,
  input  wire logic [3:0]        laneWriteStrobeA,
  input  wire logic [ADDR_W+2:0] addrA,
  input  wire logic [31:0]       writeWordA,
  input  wire logic [3:0]        writeCheckBitsA,
  input  wire logic              outputPresetA,
  input  wire logic              pipeStageGateA,
  output logic      [31:0]       readWordA,
  output logic      [3:0]        readCheckBitsA,
  // port a cascade
  input  wire logic              chainInLatchedA,
  input  wire logic              chainInPipedA,
  output logic                   chainOutLatchedA,
  output logic                   chainOutPipedA,
  // port b
  input  wire logic              portSelectB,
  input  wire logic [3:0]        laneWriteStrobeB,
  input  wire logic [ADDR_W+2:0] addrB,
  input  wire logic [31:0]       writeWordB,
  input  wire logic [3:0]        writeCheckBitsB,
  input  wire logic              outputPresetB,
  input  wire logic              pipeStageGateB,
  output logic      [31:0]       readWordB,
  output logic      [3:0]        readCheckBitsB,
  // port b cascade
  input  wire logic              chainInLatchedB,
  input  wire logic              chainInPipedB,
  output logic                   chainOutLatchedB,
  output logic                   chainOutPipedB
);
  localparam int WRL [2] = '{WR_LANES_A, WR_LANES_B};
  localparam int RDL [2] = '{RD_LANES_A, RD_LANES_B};

  typedef struct packed {
    logic [CTRL_W-1:0]     ctrl;
    logic [STAT_W-1:0]     status;
    logic [1:0][1:0]       laneSel;
    logic [1:0]            bankSel;
    logic [1:0][WORD_W-1:0] pipe;
  } st_t;

  st_t s_q;
  st_t s_d;

  localparam st_t ST_RST = '{ctrl: CTRL_RST, status: STAT_RST,
                             laneSel: '0, bankSel: '0, pipe: '0};

  // per-port views of the plain ports
  logic [1:0]             sel;
  logic [1:0][3:0]        strobe;
  logic [1:0][ADDR_W+2:0] addr;
  logic [1:0][WORD_W-1:0] inWord;
  logic [1:0]             preset;
  logic [1:0]             gate;
  logic [1:0]             chainLat;
  logic [1:0]             chainPip;
  logic [1:0][WORD_W-1:0] presetVal;

  // derived per-port controls
  wr_mode_t               mode     [2];
  logic [1:0]             pipeOn;
  logic [1:0]             bankHit;
  logic [1:0]             arrEn;
  logic [1:0][LANES-1:0]  laneWe;
  logic [1:0][WORD_W-1:0] wdataRep;
  logic [1:0][WORD_W-1:0] latchW;
  logic [1:0][WORD_W-1:0] latchView;
  logic [1:0][WORD_W-1:0] outWord;

  logic       wrCollide;
  logic       badRead;
  logic       apbAccess;
  logic       ctrlHit;
  logic       statHit;

  // lanes of the array word touched by a write of w lanes
  function automatic logic [LANES-1:0] writeLanes(
    input logic [3:0] stb, input logic [1:0] low, input int w);
    logic [LANES-1:0] r;
    r = '0;
    for (int i = 0; i < LANES; i++) begin
      if ((i / w) == (int'(low) / w)) begin
        r[i] = stb[i % w];
      end
    end
    return r;
  endfunction

  // narrow write data is repeated across the word
  function automatic word_t replicate(input word_t d, input int w);
    word_t r;
    r = '0;
    for (int i = 0; i < LANES; i++) begin
      r[i*LANE_W +: LANE_W] = d[(i % w)*LANE_W +: LANE_W];
    end
    return r;
  endfunction

  // narrow reads pick their lanes from the latched word, zero above
  function automatic word_t pickLanes(
    input word_t w, input logic [1:0] low, input int n);
    word_t r;
    int    base;
    r    = '0;
    base = (int'(low) / n) * n;
    for (int j = 0; j < LANES; j++) begin
      if (j < n) begin
        r[j*LANE_W +: LANE_W] = w[(base + j)*LANE_W +: LANE_W];
      end
    end
    return r;
  endfunction

  // lane i of a word is {check bit i, byte i}
  function automatic word_t mergeLanes(
    input logic [31:0] d, input logic [3:0] c);
    word_t r;
    r = '0;
    for (int i = 0; i < LANES; i++) begin
      r[i*LANE_W +: LANE_W] = {c[i], d[i*8 +: 8]};
    end
    return r;
  endfunction

  assign sel       = {portSelectB, portSelectA};
  assign strobe    = {laneWriteStrobeB, laneWriteStrobeA};
  assign addr      = {addrB, addrA};
  assign inWord    = {mergeLanes(writeWordB, writeCheckBitsB),
                      mergeLanes(writeWordA, writeCheckBitsA)};
  assign preset    = {outputPresetB, outputPresetA};
  assign gate      = {pipeStageGateB, pipeStageGateA};
  assign chainLat  = {chainInLatchedB, chainInLatchedA};
  assign chainPip  = {chainInPipedB, chainInPipedA};
  assign presetVal = {PRESET_B, PRESET_A};

  ram_port_if pif [2] ();

  // one block of port logic per port
  for (genvar p = 0; p < 2; p++) begin : g_port
    localparam int MPOS = (p == 0) ? MODE_A_POS : MODE_B_POS;
    localparam int PPOS = (p == 0) ? PIPE_A_POS : PIPE_B_POS;

    // mode 2'b11 behaves as the transparent default
    assign mode[p] = (s_q.ctrl[MPOS +: 2] == MODE_READ_FIRST) ?
                     MODE_READ_FIRST :
                     (s_q.ctrl[MPOS +: 2] == MODE_HOLD) ? MODE_HOLD :
                     MODE_TRANSPARENT;
    assign pipeOn[p]   = s_q.ctrl[PPOS];
    // with cascade on, only the addressed half reacts
    assign bankHit[p]  = !CHAIN_EN || (addr[p][ADDR_W+2] == CHAIN_BANK);
    assign arrEn[p]    = sel[p] && bankHit[p];
    assign laneWe[p]   = writeLanes(strobe[p], addr[p][1:0], WRL[p]);
    assign wdataRep[p] = replicate(inWord[p], WRL[p]);

    assign pif[p].en        = arrEn[p];
    assign pif[p].laneWe    = laneWe[p];
    assign pif[p].wordAddr  = addr[p][ADDR_W+1:2];
    assign pif[p].wdata     = wdataRep[p];
    assign pif[p].mode      = mode[p];
    // preset acts on whichever stage drives the output
    assign pif[p].preset    = preset[p] && !pipeOn[p];
    assign pif[p].presetVal = presetVal[p];
    assign latchW[p]        = pif[p].latch;

    assign latchView[p] = pickLanes(latchW[p], s_q.laneSel[p], RDL[p]);

    always_comb begin
      outWord[p] = pipeOn[p] ? s_q.pipe[p] : latchView[p];
      if (CHAIN_EN && (s_q.bankSel[p] != CHAIN_BANK)) begin
        outWord[p][0] = pipeOn[p] ? chainPip[p] : chainLat[p];
      end
    end
  end

  tdp_ram_array #(
    .NWORDS (DEPTH)
  ) u_array (
    .clk (clk),
    .rst (rst),
    .pa  (pif[0]),
    .pb  (pif[1])
  );

  // same-word activity on one edge; the array does not arbitrate
  always_comb begin
    wrCollide = 1'b0;
    badRead   = 1'b0;
    if (arrEn[0] && arrEn[1] &&
        (addr[0][ADDR_W+1:2] == addr[1][ADDR_W+1:2])) begin
      wrCollide = (laneWe[0] & laneWe[1]) != '0;
      for (int p = 0; p < 2; p++) begin
        // only a read-before-write writer gives the reader a clean word
        if (laneWe[p] != '0 && laneWe[1-p] == '0 &&
            mode[p] != MODE_READ_FIRST) begin
          badRead = 1'b1;
        end
      end
    end
  end

  assign apbAccess = psel && penable;
  assign ctrlHit   = (paddr == CTRL_OFS);
  assign statHit   = (paddr == STAT_OFS);
  assign pready    = 1'b1;
  assign pslverr   = apbAccess && !(ctrlHit || statHit);

  always_comb begin
    prdata = 32'h0;
    if (ctrlHit) begin
      prdata[CTRL_W-1:0] = s_q.ctrl;
    end else if (statHit) begin
      prdata[STAT_W-1:0] = s_q.status;
    end
  end

  always_comb begin
    s_d = s_q;
    if (apbAccess && pwrite) begin
      if (ctrlHit) begin
        s_d.ctrl = pwdata[CTRL_W-1:0];
      end else if (statHit) begin
        // write one to clear
        s_d.status = s_q.status & ~pwdata[STAT_W-1:0];
      end
    end
    // a fresh event beats a clear in the same cycle
    if (wrCollide) begin
      s_d.status[WCOL_POS] = 1'b1;
    end
    if (badRead) begin
      s_d.status[RBAD_POS] = 1'b1;
    end
    for (int p = 0; p < 2; p++) begin
      if (sel[p]) begin
        s_d.bankSel[p] = addr[p][ADDR_W+2];
      end
      // lane pick follows the latch: a hold-mode write keeps both
      if (arrEn[p] && !(laneWe[p] != '0 && mode[p] == MODE_HOLD)) begin
        s_d.laneSel[p] = addr[p][1:0];
      end
      // pipe stage runs on its own gate, apart from port_select
      if (pipeOn[p] && gate[p]) begin
        s_d.pipe[p] = preset[p] ? presetVal[p] : latchView[p];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // unpack lanes to byte and check-bit buses
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      readWordA[i*8 +: 8] = outWord[0][i*LANE_W +: 8];
      readCheckBitsA[i]   = outWord[0][i*LANE_W + 8];
      readWordB[i*8 +: 8] = outWord[1][i*LANE_W +: 8];
      readCheckBitsB[i]   = outWord[1][i*LANE_W + 8];
    end
  end

  assign chainOutLatchedA = latchView[0][0];
  assign chainOutLatchedB = latchView[1][0];
  assign chainOutPipedA   = s_q.pipe[0][0];
  assign chainOutPipedB   = s_q.pipe[1][0];
endmodule // true_dual_port_block_ram

// ==== hdl/tdp_ram_pkg.sv ====
// shared constants and types for the true dual-port block memory
// assumes one common clock for both ports and an APB master for setup
package tdp_ram_pkg;
  localparam int LANES  = 4;
  localparam int LANE_W = 9;
  localparam int WORD_W = LANES * LANE_W;
  localparam int DATA_W = 32;
  localparam int CHK_W  = 4;
  localparam int DEPTH  = 1024;
  localparam int ADDR_W = 10;

  // APB map
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam int CTRL_W       = 6;
  localparam int MODE_A_POS   = 0;
  localparam int MODE_B_POS   = 2;
  localparam int PIPE_A_POS   = 4;
  localparam int PIPE_B_POS   = 5;
  localparam int STAT_W       = 2;
  localparam int WCOL_POS     = 0;
  localparam int RBAD_POS     = 1;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [STAT_W-1:0] STAT_RST = 2'h0;

  typedef enum logic [1:0] {
    MODE_TRANSPARENT = 2'b00,
    MODE_READ_FIRST  = 2'b01,
    MODE_HOLD        = 2'b10
  } wr_mode_t;

  typedef logic [WORD_W-1:0] word_t;
endpackage

// ==== hdl/ram_port_if.sv ====
// one port's path between the control logic and the storage array
// assumes the array module samples all controls on the common clock
`timescale 1ns/1ps
interface ram_port_if;
  import tdp_ram_pkg::*;
  logic              en;
  logic [LANES-1:0]  laneWe;
  logic [ADDR_W-1:0] wordAddr;
  word_t             wdata;
  wr_mode_t          mode;
  logic              preset;
  word_t             presetVal;
  word_t             latch;
  modport ctrl  (output en, laneWe, wordAddr, wdata, mode, preset,
                 presetVal, input latch);
  modport array (input en, laneWe, wordAddr, wdata, mode, preset,
                 presetVal, output latch);
endinterface // ram_port_if

// ==== hdl/tdp_ram_array.sv ====
// shared storage with one output latch per port
// assumes both ports on one clock; port b write lands last on a clash
`timescale 1ns/1ps
module tdp_ram_array
  import tdp_ram_pkg::*;
#(
  parameter int NWORDS = DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  ram_port_if.array pa,
  ram_port_if.array pb
);
  typedef struct packed {
    word_t latchA;
    word_t latchB;
  } arr_st_t;

  word_t   mem [NWORDS];
  arr_st_t s_q;
  arr_st_t s_d;

  function automatic word_t nextLatch(
    input logic en, input logic [LANES-1:0] we, input wr_mode_t mode,
    input logic preset, input word_t pv, input word_t wd,
    input word_t old, input word_t cur);
    word_t r;
    r = cur;
    if (en) begin
      if (preset) begin
        r = pv;
      end else if (we == '0) begin
        r = old;
      end else if (mode == MODE_READ_FIRST) begin
        r = old;
      end else if (mode != MODE_HOLD) begin
        for (int i = 0; i < LANES; i++) begin
          // new lanes for written bytes, stored lanes elsewhere
          r[i*LANE_W +: LANE_W] = we[i] ? wd[i*LANE_W +: LANE_W]
                                        : old[i*LANE_W +: LANE_W];
        end
      end
    end
    return r;
  endfunction

  // reads see the stored word before this edge's writes
  always_comb begin
    s_d.latchA = nextLatch(pa.en, pa.laneWe, pa.mode, pa.preset,
                           pa.presetVal, pa.wdata, mem[pa.wordAddr],
                           s_q.latchA);
    s_d.latchB = nextLatch(pb.en, pb.laneWe, pb.mode, pb.preset,
                           pb.presetVal, pb.wdata, mem[pb.wordAddr],
                           s_q.latchB);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
    // no arbitration between ports
    for (int i = 0; i < LANES; i++) begin
      if (pa.en && pa.laneWe[i]) begin
        mem[pa.wordAddr][i*LANE_W +: LANE_W] <=
          pa.wdata[i*LANE_W +: LANE_W];
      end
      if (pb.en && pb.laneWe[i]) begin
        mem[pb.wordAddr][i*LANE_W +: LANE_W] <=
          pb.wdata[i*LANE_W +: LANE_W];
      end
    end
  end

  assign pa.latch = s_q.latchA;
  assign pb.latch = s_q.latchB;
endmodule // tdp_ram_array

// ==== tb/tdp_ram_props.sv ====
// checker for the dual-port memory: apb answers and output stages
// assumes one clock; control register mirrored from observed apb writes
`timescale 1ns/1ps
module tdp_ram_props
  import tdp_ram_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              rst,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // port a
  input wire logic              portSelectA,
  input wire logic [3:0]        laneWriteStrobeA,
  input wire logic [ADDR_W+2:0] addrA,
  input wire logic [31:0]       writeWordA,
  input wire logic [3:0]        writeCheckBitsA,
  input wire logic              outputPresetA,
  input wire logic              pipeStageGateA,
  input wire logic [31:0]       readWordA,
  input wire logic [3:0]        readCheckBitsA,
  // port b
  input wire logic              portSelectB,
  input wire logic [3:0]        laneWriteStrobeB,
  input wire logic [ADDR_W+2:0] addrB,
  input wire logic [31:0]       readWordB
);
  logic [5:0] ctrlQ;
  logic       ctrlWr, pipeA, pipeB, wfA;
  assign ctrlWr = psel && penable && pwrite && paddr == 12'h000;
  assign pipeA  = ctrlQ[4];
  assign pipeB  = ctrlQ[5];
  assign wfA    = ctrlQ[1:0] == 2'b00 || ctrlQ[1:0] == 2'b11;
  // a control write also swaps the output source, so such cycles are skipped
  always_ff @(posedge clk) begin
    if (rst) ctrlQ <= 6'h00;
    else if (ctrlWr) ctrlQ <= pwdata[5:0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence fullWriteA;
    portSelectA && laneWriteStrobeA == 4'hf && wfA && !outputPresetA;
  endsequence
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_unmapped_err: assert property (psel && penable |->
    pslverr == !(paddr == 12'h000 || paddr == 12'h004))
    else $error("pslverr wrong");
  a_idle_hold_a: assert property (!pipeA && !portSelectA && !ctrlWr
    |=> $stable({readCheckBitsA, readWordA})) else $error("a moved");
  a_idle_hold_b: assert property (!pipeB && !portSelectB && !ctrlWr
    |=> $stable(readWordB)) else $error("b moved");
  a_write_first: assert property (fullWriteA ##0 !pipeA && !ctrlWr
    |=> {readCheckBitsA, readWordA} ==
        {$past(writeCheckBitsA), $past(writeWordA)})
    else $error("no new word");
  a_hold_write: assert property (ctrlQ[1:0] == 2'b10 && !pipeA
    && portSelectA && laneWriteStrobeA != 4'h0 && !outputPresetA
    && !ctrlWr |=> $stable(readWordA)) else $error("hold broke");
  a_preset_latch: assert property (!pipeA && portSelectA
    && outputPresetA && !ctrlWr |=> {readCheckBitsA, readWordA} == 36'h0)
    else $error("preset missed");
  a_pipe_gate: assert property (pipeA && !pipeStageGateA && !ctrlWr
    |=> $stable({readCheckBitsA, readWordA})) else $error("pipe moved");
  a_pipe_latency: assert property (fullWriteA ##0 pipeA
    ##2 pipeStageGateA && !outputPresetA && !ctrlWr
    |=> readWordA == $past(writeWordA, 3)) else $error("pipe late");
  a_rbw_both_old: assert property (ctrlQ[1:0] == 2'b01 && !pipeA
    && !pipeB && portSelectA && laneWriteStrobeA == 4'hf && !ctrlWr
    && portSelectB && laneWriteStrobeB == 4'h0 && !outputPresetA
    && addrA[11:2] == addrB[11:2] |=> readWordB == readWordA)
    else $error("ports disagree");
endmodule // tdp_ram_props

// ==== tb/user_port_model.sv ====
// user logic on one memory port: one access per call, then one idle cycle
// assumes the memory samples its port inputs on the rising edge of clk
`timescale 1ns/1ps
module user_port_model (
  // clock
  input wire logic clk,
  // port pins towards the memory
  output logic        sel    = 1'b0,
  output logic [3:0]  stb    = 4'h0,
  output logic [12:0] addr   = 13'h0,
  output logic [31:0] data   = 32'h0,
  output logic [3:0]  chk    = 4'h0,
  output logic        preset = 1'b0,
  output logic        gate   = 1'b0
);
  // same-word writes from both ports happen only when a test asks
  // one shared clock, so no access lands in a cross-clock window
  task automatic xfer(input logic s, input logic [3:0] w,
                      input logic [9:0] idx, input logic [31:0] d,
                      input logic [3:0] c, input logic p, input logic g);
    @(posedge clk);
    sel    <= s;
    stb    <= w;
    addr   <= {1'b0, idx, 2'b00};
    data   <= d;
    chk    <= c;
    preset <= p;
    gate   <= g;
    @(posedge clk);
    sel    <= 1'b0;
    stb    <= 4'h0;
    preset <= 1'b0;
    gate   <= 1'b0;
    // released data lines never keep the last value
    data   <= ~d;
    chk    <= ~c;
  endtask
endmodule // user_port_model

// ==== tb/tb_top.sv ====
// bench for the dual-port memory: apb setup plus port scenarios
// assumes the memory answers apb within 20 cycles and ports in one edge
`timescale 1ns/1ps
module tb_top;
  import tdp_ram_pkg::*;
  logic clk = 1'b0, rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdata, readWordA, readWordB;
  logic pready, pslverr, rerr;
  logic portSelectA, outputPresetA, pipeStageGateA;
  logic portSelectB, outputPresetB, pipeStageGateB;
  logic [3:0] laneWriteStrobeA, writeCheckBitsA, readCheckBitsA;
  logic [3:0] laneWriteStrobeB, writeCheckBitsB, readCheckBitsB;
  logic [12:0] addrA, addrB;
  logic [31:0] writeWordA, writeWordB;
  logic chainLatA, chainPipA, chainLatB, chainPipB;
  int errors = 0, compares = 0;
  initial forever #20 clk = ~clk;
  user_port_model userA (.clk, .sel(portSelectA), .stb(laneWriteStrobeA),
    .addr(addrA), .data(writeWordA), .chk(writeCheckBitsA),
    .preset(outputPresetA), .gate(pipeStageGateA));
  user_port_model userB (.clk, .sel(portSelectB), .stb(laneWriteStrobeB),
    .addr(addrB), .data(writeWordB), .chk(writeCheckBitsB),
    .preset(outputPresetB), .gate(pipeStageGateB));
  true_dual_port_block_ram true_dual_port_block_ram_inst (.clk, .rst,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .portSelectA, .laneWriteStrobeA, .addrA, .writeWordA, .writeCheckBitsA,
    .outputPresetA, .pipeStageGateA, .readWordA, .readCheckBitsA,
    .chainInLatchedA(1'b0), .chainInPipedA(1'b0),
    .chainOutLatchedA(chainLatA), .chainOutPipedA(chainPipA),
    .portSelectB, .laneWriteStrobeB, .addrB, .writeWordB,
    .writeCheckBitsB, .outputPresetB, .pipeStageGateB, .readWordB,
    .readCheckBitsB, .chainInLatchedB(1'b0), .chainInPipedB(1'b0),
    .chainOutLatchedB(chainLatB), .chainOutPipedB(chainPipB));
  task automatic complete_run();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      errors++;
      complete_run();
    end
    rdata   = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, CTRL_OFS, 32'h0);
    check({3'h0, rerr, rdata}, 36'h0);
    apb(1'b0, STAT_OFS, 32'h0);
    check({3'h0, rerr, rdata}, 36'h0);
    apb(1'b1, CTRL_OFS, 32'hffffffff);
    apb(1'b0, CTRL_OFS, 32'h0);
    check({3'h0, rerr, rdata}, {4'h0, 32'h3f});
    apb(1'b1, 12'h008, 32'h0);
    check({3'h0, rerr, rdata}, {4'h1, 32'h0});
    apb(1'b1, CTRL_OFS, 32'h0);
    $display("test registers done");
    userA.xfer(1'b1, 4'hf, 10'h005, 32'h11223344, 4'h3, 1'b0, 1'b0);
    #1 check({readCheckBitsA, readWordA}, {4'h3, 32'h11223344});
    userB.xfer(1'b1, 4'h0, 10'h005, 32'h0, 4'h0, 1'b0, 1'b0);
    #1 check({readCheckBitsB, readWordB}, {4'h3, 32'h11223344});
    userA.xfer(1'b1, 4'h5, 10'h005, 32'haabbccdd, 4'hc, 1'b0, 1'b0);
    #1 check({readCheckBitsA, readWordA}, {4'h6, 32'h11bb33dd});
    check({35'h0, chainLatA}, 36'h1);
    $display("test transparent done");
    apb(1'b1, CTRL_OFS, 32'h1);
    fork
      userA.xfer(1'b1, 4'hf, 10'h005, 32'hcafef00d, 4'h9, 1'b0, 1'b0);
      userB.xfer(1'b1, 4'h0, 10'h005, 32'h0, 4'h0, 1'b0, 1'b0);
    join
    #1 check({readCheckBitsA, readWordA}, {4'h6, 32'h11bb33dd});
    check({readCheckBitsB, readWordB}, {4'h6, 32'h11bb33dd});
    userB.xfer(1'b1, 4'h0, 10'h005, 32'h0, 4'h0, 1'b0, 1'b0);
    #1 check({readCheckBitsB, readWordB}, {4'h9, 32'hcafef00d});
    check({34'h0, chainLatB, chainPipB}, 36'h2);
    $display("test read first done");
    apb(1'b1, CTRL_OFS, 32'h2);
    userA.xfer(1'b1, 4'h0, 10'h005, 32'h0, 4'h0, 1'b0, 1'b0);
    userA.xfer(1'b1, 4'hf, 10'h006, 32'h01020304, 4'h1, 1'b0, 1'b0);
    #1 check({readCheckBitsA, readWordA}, {4'h9, 32'hcafef00d});
    userA.xfer(1'b0, 4'hf, 10'h006, 32'hffffffff, 4'hf, 1'b0, 1'b0);
    #1 check({readCheckBitsA, readWordA}, {4'h9, 32'hcafef00d});
    userB.xfer(1'b1, 4'h0, 10'h006, 32'h0, 4'h0, 1'b0, 1'b0);
    #1 check({readCheckBitsB, readWordB}, {4'h1, 32'h01020304});
    $display("test hold and idle done");
    apb(1'b1, CTRL_OFS, 32'h10);
    userA.xfer(1'b1, 4'hf, 10'h008, 32'h0a0b0c0d, 4'h2, 1'b0, 1'b0);
    #1 check({readCheckBitsA, readWordA}, 36'h0);
    userA.xfer(1'b0, 4'h0, 10'h000, 32'h0, 4'h0, 1'b0, 1'b1);
    #1 check({readCheckBitsA, readWordA}, {4'h2, 32'h0a0b0c0d});
    check({35'h0, chainPipA}, 36'h1);
    userA.xfer(1'b0, 4'h0, 10'h000, 32'h0, 4'h0, 1'b1, 1'b1);
    #1 check({readCheckBitsA, readWordA}, 36'h0);
    apb(1'b1, CTRL_OFS, 32'h0);
    #1 check({readCheckBitsA, readWordA}, {4'h2, 32'h0a0b0c0d});
    userA.xfer(1'b1, 4'h0, 10'h008, 32'h0, 4'h0, 1'b1, 1'b0);
    #1 check({readCheckBitsA, readWordA}, 36'h0);
    $display("test pipe and preset done");
    fork
      userA.xfer(1'b1, 4'hf, 10'h007, 32'h1, 4'h0, 1'b0, 1'b0);
      userB.xfer(1'b1, 4'hf, 10'h007, 32'h2, 4'h0, 1'b0, 1'b0);
    join
    apb(1'b0, STAT_OFS, 32'h0);
    check({35'h0, rdata[0]}, 36'h1);
    apb(1'b1, STAT_OFS, 32'h3);
    apb(1'b0, STAT_OFS, 32'h0);
    check({4'h0, rdata}, 36'h0);
    fork
      userA.xfer(1'b1, 4'hf, 10'h007, 32'h3, 4'h0, 1'b0, 1'b0);
      userB.xfer(1'b1, 4'h0, 10'h007, 32'h0, 4'h0, 1'b0, 1'b0);
    join
    apb(1'b0, STAT_OFS, 32'h0);
    check({35'h0, rdata[1]}, 36'h1);
    $display("test conflicts done");
    complete_run();
  end
endmodule // tb_top
bind true_dual_port_block_ram tdp_ram_props tdp_ram_props_inst (.clk, .rst,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .portSelectA, .laneWriteStrobeA, .addrA, .writeWordA, .writeCheckBitsA,
  .outputPresetA, .pipeStageGateA, .readWordA, .readCheckBitsA,
  .portSelectB, .laneWriteStrobeB, .addrB, .readWordB);
